/* verilog/shift_latch_regs.vh */
// constants for the serial-in parallel-out shift latch
`ifndef SHIFT_LATCH_REGS_VH
`define SHIFT_LATCH_REGS_VH
`define STAGE_COUNT     8
`define LAST_STAGE      7
`define FIRST_STAGE     0
`define CLEAR_BYTE      8'h00
`define FIFO_WORD_WIDTH 8
`define FIFO_DEPTH      16
`define FIFO_PTR_WIDTH  4
`define SYNC_IDLE       5'h18
`endif

/* verilog/shift_latch.v */
// serial-in parallel-out shift register with storage latch and output fifo
`timescale 1ns/1ps
`include "shift_latch_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// fifo with parameterised width and depth, valid/ready on both sides
module byte_fifo #(
    parameter WIDTH = `FIFO_WORD_WIDTH,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW    = `FIFO_PTR_WIDTH
) (
    input  wire             clk_i,     // system clock
    input  wire             rst_n_i,   // async reset, active low
    input  wire [WIDTH-1:0] in_data_i, // word to store
    input  wire             in_valid_i,// word offered
    output wire             in_ready_o,// room available
    output wire [WIDTH-1:0] out_data_o,// oldest word
    output wire             out_valid_o,// word available
    input  wire             out_ready_i // drain side accepts
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready_o  = (cnt_q != DEPTH);
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // storage array has no reset; only pointers and fill count need a defined value
    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_q] <= in_data_i;
        end
    end

    // pointers and fill count
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// top: pins sampled by CLK_I, edges found, registers emulated synchronously
module shift_latch #(
    parameter STAGES = `STAGE_COUNT
) (
    input  wire              CLK_I,                // system clock, 10 MHz
    input  wire              RST_N_I,              // async reset, active low
    input  wire              SERIAL_DATA_IN_I,     // serial data pin
    input  wire              SHIFT_CLOCK_I,        // shift clock pin
    input  wire              STORAGE_CLOCK_I,      // storage clock pin
    input  wire              SHIFT_CLEAR_N_I,      // shift register clear, low
    input  wire              STORAGE_CLEAR_N_I,    // storage register clear, low
    output reg  [STAGES-1:0] PARALLEL_OUT_O,       // storage register outputs
    output reg               SERIAL_CASCADE_OUT_O, // last shift stage
    output reg  [STAGES-1:0] WORD_DATA_O,          // latched word stream
    output reg               WORD_VALID_O,         // word stream valid
    input  wire              WORD_READY_I          // word stream accepted
);
    // synchroniser stages: first flop read only by the second
    reg [4:0]        meta_q;
    reg [4:0]        sync_q;
    reg              shclk_prev_q;
    reg              stclk_prev_q;
    reg [STAGES-1:0] shift_q;
    wire             din;
    wire             shclk;
    wire             stclk;
    wire             shclr_n;
    wire             stclr_n;
    wire             shift_edge;
    wire             store_edge;
    wire             fifo_ready;
    wire             fifo_valid;
    wire [STAGES-1:0] fifo_data;
    wire             out_take;

    assign din     = sync_q[0];
    assign shclk   = sync_q[1];
    assign stclk   = sync_q[2];
    assign shclr_n = sync_q[3];
    assign stclr_n = sync_q[4];

    // two-flop synchronisers for every pin; clears idle high (inactive)
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            meta_q <= `SYNC_IDLE;
            sync_q <= `SYNC_IDLE;
        end else begin
            meta_q <= {STORAGE_CLEAR_N_I, SHIFT_CLEAR_N_I, STORAGE_CLOCK_I,
                       SHIFT_CLOCK_I, SERIAL_DATA_IN_I};
            sync_q <= meta_q;
        end
    end

    // edge detectors; data and clock share sync latency, so setup is kept
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            shclk_prev_q <= 1'b0;
            stclk_prev_q <= 1'b0;
        end else begin
            shclk_prev_q <= shclk;
            stclk_prev_q <= stclk;
        end
    end

    assign shift_edge = shclk & ~shclk_prev_q;
    assign store_edge = stclk & ~stclk_prev_q;

    // shift register: clear wins over a coincident edge
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            shift_q <= `CLEAR_BYTE;
        end else if (!shclr_n) begin
            shift_q <= `CLEAR_BYTE;
        end else if (shift_edge) begin
            shift_q <= {shift_q[STAGES-2:0], din};
        end
    end

    // cascade output mirrors the last stage, updated in the same cycle as shift_q
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            SERIAL_CASCADE_OUT_O <= 1'b0;
        end else if (!shclr_n) begin
            SERIAL_CASCADE_OUT_O <= 1'b0;
        end else if (shift_edge) begin
            SERIAL_CASCADE_OUT_O <= shift_q[STAGES-2];
        end else begin
            SERIAL_CASCADE_OUT_O <= shift_q[`LAST_STAGE];
        end
    end

    // storage register reads the old shift_q, so shared clocks lag one shift
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PARALLEL_OUT_O <= `CLEAR_BYTE;
        end else if (!stclr_n) begin
            PARALLEL_OUT_O <= `CLEAR_BYTE;
        end else if (store_edge) begin
            PARALLEL_OUT_O <= shift_q;
        end
    end

    // each storage transfer is also queued; a full fifo drops the word
    // rather than stalling, since the pins cannot be held off
    byte_fifo #(
        .WIDTH (STAGES),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_PTR_WIDTH)
    ) u_fifo (
        .clk_i       (CLK_I),
        .rst_n_i     (RST_N_I),
        .in_data_i   (shift_q),
        .in_valid_i  (store_edge & stclr_n),
        .in_ready_o  (fifo_ready),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (out_take)
    );

    // registered output stage for the word stream
    assign out_take = fifo_valid & (~WORD_VALID_O | WORD_READY_I);

    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            WORD_VALID_O <= 1'b0;
            WORD_DATA_O  <= `CLEAR_BYTE;
        end else if (out_take) begin
            WORD_VALID_O <= 1'b1;
            WORD_DATA_O  <= fifo_data;
        end else if (WORD_READY_I) begin
            WORD_VALID_O <= 1'b0;
        end
    end
endmodule

/* sim/shift_latch_sva.sv */
// port checker for the shift latch
`timescale 1ns/1ps
module shift_latch_sva #(parameter STAGES = 8) (
    input wire              CLK_I, RST_N_I, SERIAL_DATA_IN_I, SHIFT_CLOCK_I,
    input wire              STORAGE_CLOCK_I, SHIFT_CLEAR_N_I, STORAGE_CLEAR_N_I,
    input wire              SERIAL_CASCADE_OUT_O, WORD_VALID_O, WORD_READY_I,
    input wire [STAGES-1:0] PARALLEL_OUT_O, WORD_DATA_O
);
    reg [3:0] sh_q, st_q; // edges since the last pin event, saturating
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // outputs lag the pins by a few edges, so changes are judged by age
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sh_q <= 4'h0;
            st_q <= 4'h0;
        end else begin
            sh_q <= ($rose(SHIFT_CLOCK_I) || !SHIFT_CLEAR_N_I) ? 4'h0 : sh_q + {3'h0, ~&sh_q};
            st_q <= ($rose(STORAGE_CLOCK_I) || !STORAGE_CLEAR_N_I) ? 4'h0 : st_q + {3'h0, ~&st_q};
        end
    end
    sequence s_store; $rose(STORAGE_CLOCK_I) && STORAGE_CLEAR_N_I; endsequence
    sequence s_calm; (SHIFT_CLEAR_N_I && STORAGE_CLEAR_N_I && !$rose(SHIFT_CLOCK_I)) [*6]; endsequence
    chk_store_word: assert property (s_store |-> ##[1:8] WORD_VALID_O)
        else $error("no word after storage edge");
    chk_store_casc: assert property (s_store ##0 (!$rose(SHIFT_CLOCK_I) && sh_q > 4'h8) ##1 s_calm
        |-> PARALLEL_OUT_O[STAGES-1] == SERIAL_CASCADE_OUT_O)
        else $error("cascade differs from stored last stage");
    chk_par_hold: assert property ($changed(PARALLEL_OUT_O) |-> st_q < 4'h6)
        else $error("outputs moved without storage event");
    chk_casc_hold: assert property ($changed(SERIAL_CASCADE_OUT_O) |-> sh_q < 4'h6)
        else $error("cascade moved without shift event");
    chk_par_clear: assert property (!STORAGE_CLEAR_N_I [*5] |-> ~|PARALLEL_OUT_O)
        else $error("outputs not cleared");
    chk_casc_clear: assert property (!SHIFT_CLEAR_N_I [*5] |-> !SERIAL_CASCADE_OUT_O)
        else $error("cascade not cleared");
    chk_clear_wins: assert property (!STORAGE_CLEAR_N_I [*3] ##0 $rose(STORAGE_CLOCK_I)
        ##1 (!$rose(STORAGE_CLOCK_I)) [*5] |-> ~|PARALLEL_OUT_O) else $error("edge beat clear");
    chk_word_hold: assert property (WORD_VALID_O && !WORD_READY_I |=> WORD_VALID_O
        && $stable(WORD_DATA_O)) else $error("word dropped while stalled");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind shift_latch shift_latch_sva #(.STAGES(STAGES)) i_shift_latch_sva (.*);

/* sim/host_model.sv */
// host controller model driving the latch pins
`timescale 1ns/1ps
module host_model (
    input  wire clk_i, // system clock
    output reg  ds_o,  // serial data
    output reg  shc_o, // shift clock
    output reg  stc_o, // storage clock
    output reg  shn_o, // shift clear, low
    output reg  stn_o  // storage clear, low
);
    initial {ds_o, shc_o, stc_o, shn_o, stn_o} = 5'h03;
    // one 800 ns link period; clocks rest low between frames
    task pulse(input sh, input st, input b);
        begin
            ds_o <= b;
            repeat (3) @(posedge clk_i);
            shc_o <= sh;
            stc_o <= st;
            repeat (4) @(posedge clk_i);
            shc_o <= 1'b0;
            stc_o <= 1'b0;
            ds_o <= ~b; // data is not held past its hold time
            @(posedge clk_i);
        end
    endtask
    // clears change only just after a rising edge
    task clr(input a, input b);
        begin
            @(posedge clk_i);
            {shn_o, stn_o} <= {a, b};
        end
    endtask
endmodule

/* sim/tb_top.sv */
// self-checking bench for the shift latch
`timescale 1ns/1ps
module tb_top;
    reg         clk = 1'b0, rst_n = 1'b0, rdy = 1'b1;
    wire        ds, shc, stc, shn, stn, casc, vld;
    wire [7:0]  par, wd;
    integer     num_errors = 0, n_checks = 0, i, n;
    localparam [7:0] PAT = 8'hA5;
    initial forever #50 clk = ~clk;
    host_model i_host_model (.clk_i(clk), .ds_o(ds), .shc_o(shc), .stc_o(stc), .shn_o(shn),
        .stn_o(stn));
    shift_latch i_shift_latch (.CLK_I(clk), .RST_N_I(rst_n), .SERIAL_DATA_IN_I(ds),
        .SHIFT_CLOCK_I(shc), .STORAGE_CLOCK_I(stc), .SHIFT_CLEAR_N_I(shn),
        .STORAGE_CLEAR_N_I(stn), .PARALLEL_OUT_O(par), .SERIAL_CASCADE_OUT_O(casc),
        .WORD_DATA_O(wd), .WORD_VALID_O(vld), .WORD_READY_I(rdy));
    task cmp(input [8:0] got, input [8:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("BAD %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // let the synchronised pins settle, then judge cascade and outputs
    task look(input [8:0] exp);
        begin
            repeat (4) @(negedge clk);
            cmp({casc, par}, exp);
        end
    endtask
    task t_shift;
        begin
            for (i = 7; i >= 0; i = i - 1) i_host_model.pulse(1'b1, 1'b0, PAT[i]);
            look({1'b1, 8'h00});
            i_host_model.pulse(1'b0, 1'b1, 1'b0);
            look({1'b1, PAT});
        end
    endtask
    task t_shared;
        begin
            i_host_model.pulse(1'b1, 1'b1, 1'b0);
            look({1'b0, PAT});
        end
    endtask
    task t_clear;
        begin
            i_host_model.clr(1'b0, 1'b1);
            i_host_model.pulse(1'b1, 1'b0, 1'b1);
            look({1'b0, 8'hA5});
            i_host_model.clr(1'b1, 1'b1);
            i_host_model.pulse(1'b1, 1'b0, 1'b1);
            i_host_model.pulse(1'b0, 1'b1, 1'b0);
            look({1'b0, 8'h01});
            i_host_model.clr(1'b1, 1'b0);
            i_host_model.pulse(1'b0, 1'b1, 1'b0);
            look({1'b0, 8'h00});
            i_host_model.clr(1'b1, 1'b1);
        end
    endtask
    // stall the stream past its depth; overflow words are dropped
    task t_fifo;
        begin
            rdy <= 1'b0;
            repeat (18) i_host_model.pulse(1'b0, 1'b1, 1'b0);
            rdy <= 1'b1;
            n = 0;
            repeat (40) begin
                @(negedge clk);
                if (vld === 1'b1) begin
                    n = n + 1;
                    cmp({1'b0, wd}, 9'h001);
                end
            end
            cmp({8'h00, n == 17}, 9'h001);
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", n_checks, num_errors);
            if (num_errors == 0 && n_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_shift;
        t_shared;
        t_clear;
        t_fifo;
        stop_test;
    end
endmodule
